// *** verilog/ccrb_defines.svh ***
`ifndef CCRB_DEFINES_SVH
`define CCRB_DEFINES_SVH
// Notes on behaviour
// - Register settings only act in extended mode.
// - No power-on reset; host writes every register. Device NRST here loads defaults.
// - Pin-mode level on select pin loads defaults.
// - Address map: 0,1,2,3,A,B,C,D,E; rest reserved.
// - Calibration bit not self-clearing; rewrite 0 then 1.
// - Calibration bit ORed with calibration pin.
// - Phase bit: 0 or 90 degrees, demux only.
// - Swing bit selects output level; resets high.
// - Pattern bit drives fixed test pattern.
// - I power-down bit, pin also active.
// - Q power-down bit, pin also active.
// - Host sets slow-clock bit at low sampling rate.
// - Dual-edge bit selects interleaved sampling mode.
// - Host sets Q input bit in dual-edge mode.
// - Format bit: offset binary or two's complement.
// - Host writes zero to reserved config bits.
// - Frame: rw, 10b, address, dont-care, 16 data.
// - Reads of reserved addresses return zeros.
// - Registers retained through power-down.

// --------
// Register map
// --------
`define CCRB_A_MAIN 4'h0
`define CCRB_A_CMT 4'h1
`define CCRB_A_IOFS 4'h2
`define CCRB_A_IFSR 4'h3
`define CCRB_A_QOFS 4'ha
`define CCRB_A_QFSR 4'hb
`define CCRB_A_DLYC 4'hc
`define CCRB_A_DLYF 4'hd
`define CCRB_A_SYNC 4'he
`define CCRB_IMPL_MASK 16'h7c0f
`define CCRB_DEF_MAIN 16'h2000
`define CCRB_DEF_CMT 16'h2a00
`define CCRB_DEF_IOFS 16'h0000
`define CCRB_DEF_IFSR 16'h4000
`define CCRB_DEF_QOFS 16'h0000
`define CCRB_DEF_QFSR 16'h0000
`define CCRB_DEF_DLYC 16'h0000
`define CCRB_DEF_DLYF 16'h0000
`define CCRB_DEF_SYNC 16'h0000
`define CCRB_ZERO 16'h0000

// --------
// Main configuration fields
// --------
`define CCRB_B_CAL 4'hf
`define CCRB_B_DPS 4'he
`define CCRB_B_OVS 4'hd
`define CCRB_B_TPM 4'hc
`define CCRB_B_PDI 4'hb
`define CCRB_B_PDQ 4'ha
`define CCRB_B_LFS 4'h8
`define CCRB_B_DES 4'h7
`define CCRB_B_DUAL_EDGE_Q_INPUT_SELECT 4'h6
`define CCRB_B_2SC 4'h4
`define CCRB_MAIN_WMASK 16'hfdd0
`define CCRB_M_LFS 16'h0100
`define CCRB_M_DUAL_EDGE_Q_INPUT_SELECT 16'h0040

// --------
// Serial frame
// --------
`define CCRB_RSV_CODE 2'h2
`define CCRB_FRAME_BITS 5'h18
`define CCRB_FRAME_LAST 5'h17
`define CCRB_CMD_LAST 5'h07
`define CCRB_DATA_BITS 5'h10
`define CCRB_HALF_LAST 4'hb
`define CCRB_PIN_RST 7'h09

// --------
// Host Wishbone registers
// --------
`define CCRB_WB_CMD 4'h0
`define CCRB_WB_STAT 4'h4
`define CCRB_F_DATA 15:0
`define CCRB_F_ADDR 19:16
`define CCRB_F_RD 20
`endif

// *** verilog/ccrb_pkg.sv ***
`include "ccrb_defines.svh"
package ccrb_pkg;
    typedef logic [15:0] ccrb_word_t;
    typedef logic [3:0] ccrb_addr_t;
    typedef enum {H_INIT, H_IDLE, H_LOW, H_HIGH, H_GAP} ccrb_hstate_t;

    function automatic ccrb_word_t ccrb_default(input ccrb_addr_t a);
        ccrb_word_t v;
        v = `CCRB_ZERO;
        unique case (a)
            `CCRB_A_MAIN: v = `CCRB_DEF_MAIN;
            `CCRB_A_CMT: v = `CCRB_DEF_CMT;
            `CCRB_A_IOFS: v = `CCRB_DEF_IOFS;
            `CCRB_A_IFSR: v = `CCRB_DEF_IFSR;
            `CCRB_A_QOFS: v = `CCRB_DEF_QOFS;
            `CCRB_A_QFSR: v = `CCRB_DEF_QFSR;
            `CCRB_A_DLYC: v = `CCRB_DEF_DLYC;
            `CCRB_A_DLYF: v = `CCRB_DEF_DLYF;
            `CCRB_A_SYNC: v = `CCRB_DEF_SYNC;
            default: v = `CCRB_ZERO;
        endcase
        return v;
    endfunction
endpackage

// *** verilog/ccrb_link_if.sv ***
`timescale 1ns/1ps
interface ccrb_link_if;
    logic scs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // Undriven line reads low; no float modelled
    assign sdo_line = sdo_oe & sdo;

    modport device(
        input scs_n,
        input sclk,
        input sdi,
        output sdo,
        output sdo_oe
    );

    modport host(
        output scs_n,
        output sclk,
        output sdi,
        input sdo_line
    );
endinterface

// *** verilog/ccrb_device.sv ***
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "ccrb_defines.svh"
module ccrb_device
    import ccrb_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    ccrb_link_if.device LINK,
    input wire logic EXT_CONTROL_SELECT_PIN,
    input wire logic CAL_PIN,
    input wire logic CHAN_I_POWERDOWN_PIN,
    input wire logic CHAN_Q_POWERDOWN_PIN,
    output logic EXTENDED_CTRL_MODE,
    output logic CAL_START,
    output logic DDR_PHASE_SELECT,
    output logic OUTPUT_SWING_HIGH,
    output logic PATTERN_OUTPUT_SELECT,
    output logic CHAN_I_POWERDOWN,
    output logic CHAN_Q_POWERDOWN,
    output logic SLOW_CLOCK_SELECT,
    output logic DUAL_EDGE_MODE,
    output logic DUAL_EDGE_Q_INPUT_SELECT,
    output logic TWOS_COMP_FORMAT,
    output ccrb_word_t COMMON_MODE_TRIM,
    output ccrb_word_t I_OFFSET_TRIM,
    output ccrb_word_t I_FULL_SCALE_TRIM,
    output ccrb_word_t Q_OFFSET_TRIM,
    output ccrb_word_t Q_FULL_SCALE_TRIM,
    output ccrb_word_t DELAY_COARSE,
    output ccrb_word_t DELAY_FINE_FILTER,
    output ccrb_word_t SYNC_CTRL
);
    localparam logic [6:0] PIN_RST = `CCRB_PIN_RST;
    localparam logic [15:0] IMPL = `CCRB_IMPL_MASK;

    // --------
    // Pin synchronisers
    // --------
    logic [6:0] pin_raw;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] pin_f;

    assign pin_raw = {CHAN_Q_POWERDOWN_PIN, CHAN_I_POWERDOWN_PIN, CAL_PIN,
                      EXT_CONTROL_SELECT_PIN, LINK.sdi, LINK.sclk, LINK.scs_n};

    // Filtered level moves only once stages two and three agree
    for (genvar p = 0; p < 7; p++) begin : g_pin
        always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
                sync1[p] <= PIN_RST[p];
                sync2[p] <= PIN_RST[p];
                sync3[p] <= PIN_RST[p];
                pin_f[p] <= PIN_RST[p];
            end else begin
                sync1[p] <= pin_raw[p];
                sync2[p] <= sync1[p];
                sync3[p] <= sync2[p];
                if (sync2[p] == sync3[p]) begin
                    pin_f[p] <= sync3[p];
                end
            end
        end
    end

    wire scs_act = ~pin_f[0];
    wire sclk_lvl = pin_f[1];
    wire sdi_lvl = pin_f[2];
    wire pin_mode = pin_f[3];
    wire extended_ctrl_mode = ~pin_mode;
    wire cal_pin_lvl = pin_f[4];
    wire pdi_pin_lvl = pin_f[5];
    wire pdq_pin_lvl = pin_f[6];

    // --------
    // Serial frame engine
    // --------
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [22:0] shift_in;
    logic rd_op;
    ccrb_word_t out_sh;
    ccrb_word_t regs [16];

    wire sclk_rise = sclk_lvl & ~sclk_prev;
    wire sclk_fall = ~sclk_lvl & sclk_prev;
    wire cmd_rise = scs_act & sclk_rise & (bit_cnt == `CCRB_CMD_LAST);
    wire last_rise = scs_act & sclk_rise & (bit_cnt == `CCRB_FRAME_LAST);

    // Command byte as seen at the eighth rising edge
    wire cmd_rd = shift_in[6];
    wire [1:0] cmd_rsv = shift_in[5:4];
    wire [3:0] cmd_addr = shift_in[3:0];
    wire cmd_ok = (cmd_rsv == `CCRB_RSV_CODE);
    wire [15:0] rd_word = (IMPL[cmd_addr] && cmd_ok) ? regs[cmd_addr] : `CCRB_ZERO;

    // Whole frame as seen at the 24th rising edge
    wire [23:0] frame = {shift_in, sdi_lvl};
    wire frm_rd = frame[23];
    wire [1:0] frm_rsv = frame[22:21];
    wire [3:0] wr_addr = frame[20:17];
    wire [15:0] wr_data = frame[15:0];
    // Writes commit only on the 24th edge; a short frame writes nothing
    wire wr_fire = last_rise & ~frm_rd & (frm_rsv == `CCRB_RSV_CODE) & extended_ctrl_mode;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sclk_prev <= 1'h0;
        end else begin
            sclk_prev <= sclk_lvl;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            bit_cnt <= 5'h00;
            shift_in <= 23'h000000;
        end else if (!scs_act) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && bit_cnt != `CCRB_FRAME_BITS) begin
            shift_in <= {shift_in[21:0], sdi_lvl};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Data leaves on falling edges from the eighth one; D0 repeats
    // while the select stays low past the frame end.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rd_op <= 1'h0;
            out_sh <= `CCRB_ZERO;
            LINK.sdo <= 1'h0;
            LINK.sdo_oe <= 1'h0;
        end else if (!scs_act) begin
            rd_op <= 1'h0;
            LINK.sdo_oe <= 1'h0;
        end else if (cmd_rise) begin
            rd_op <= cmd_rd;
            out_sh <= rd_word;
        end else if (sclk_fall && rd_op) begin
            LINK.sdo_oe <= 1'h1;
            LINK.sdo <= out_sh[15];
            out_sh <= {out_sh[14:0], out_sh[0]};
        end
    end

    // --------
    // Register storage
    // --------
    for (genvar r = 0; r < 16; r++) begin : g_reg
        localparam logic [3:0] IDX = 4'(r);
        if (IMPL[r]) begin : g_impl
            ccrb_word_t q;
            // Power-down states have no path here, so contents stay
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    q <= ccrb_default(IDX);
                end else if (pin_mode) begin
                    q <= ccrb_default(IDX);
                end else if (wr_fire && wr_addr == IDX) begin
                    q <= wr_data;
                end
            end
            assign regs[r] = q;
        end else begin : g_rsv
            // Nothing to store, so a reserved write changes nothing
            assign regs[r] = `CCRB_ZERO;
        end
    end

    assign COMMON_MODE_TRIM = regs[`CCRB_A_CMT];
    assign I_OFFSET_TRIM = regs[`CCRB_A_IOFS];
    assign I_FULL_SCALE_TRIM = regs[`CCRB_A_IFSR];
    assign Q_OFFSET_TRIM = regs[`CCRB_A_QOFS];
    assign Q_FULL_SCALE_TRIM = regs[`CCRB_A_QFSR];
    assign DELAY_COARSE = regs[`CCRB_A_DLYC];
    assign DELAY_FINE_FILTER = regs[`CCRB_A_DLYF];
    assign SYNC_CTRL = regs[`CCRB_A_SYNC];

    // --------
    // Effective configuration
    // --------
    // Pin mode falls back to defaults whatever the storage holds
    wire [15:0] main_eff = extended_ctrl_mode ? regs[`CCRB_A_MAIN] : `CCRB_DEF_MAIN;
    wire cal_req = (extended_ctrl_mode & main_eff[`CCRB_B_CAL]) | cal_pin_lvl;
    logic cal_prev;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cal_prev <= 1'h0;
            CAL_START <= 1'h0;
        end else begin
            cal_prev <= cal_req;
            // A held request gives one pulse; both sources must drop first
            CAL_START <= cal_req & ~cal_prev;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            EXTENDED_CTRL_MODE <= 1'h0;
            DDR_PHASE_SELECT <= 1'h0;
            OUTPUT_SWING_HIGH <= 1'h1;
            PATTERN_OUTPUT_SELECT <= 1'h0;
            CHAN_I_POWERDOWN <= 1'h0;
            CHAN_Q_POWERDOWN <= 1'h0;
            SLOW_CLOCK_SELECT <= 1'h0;
            DUAL_EDGE_MODE <= 1'h0;
            DUAL_EDGE_Q_INPUT_SELECT <= 1'h0;
            TWOS_COMP_FORMAT <= 1'h0;
        end else begin
            EXTENDED_CTRL_MODE <= extended_ctrl_mode;
            DDR_PHASE_SELECT <= main_eff[`CCRB_B_DPS];
            OUTPUT_SWING_HIGH <= main_eff[`CCRB_B_OVS];
            PATTERN_OUTPUT_SELECT <= main_eff[`CCRB_B_TPM];
            CHAN_I_POWERDOWN <= main_eff[`CCRB_B_PDI] | pdi_pin_lvl;
            CHAN_Q_POWERDOWN <= main_eff[`CCRB_B_PDQ] | pdq_pin_lvl;
            SLOW_CLOCK_SELECT <= main_eff[`CCRB_B_LFS];
            DUAL_EDGE_MODE <= main_eff[`CCRB_B_DES];
            DUAL_EDGE_Q_INPUT_SELECT <= main_eff[`CCRB_B_DUAL_EDGE_Q_INPUT_SELECT];
            TWOS_COMP_FORMAT <= main_eff[`CCRB_B_2SC];
        end
    end
endmodule

// *** verilog/ccrb_host.sv ***
`timescale 1ns/1ps
`include "ccrb_defines.svh"
module ccrb_host
    import ccrb_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic LOW_RATE_CLOCK,
    ccrb_link_if.host LINK
);
    ccrb_hstate_t state;
    logic [20:0] cmd;
    ccrb_word_t rdata;
    logic init_done;
    logic [3:0] init_addr;
    logic [3:0] tick_cnt;
    logic [4:0] bits_left;
    logic [23:0] frame;
    logic [2:0] sdo_sync;
    logic sdo_f;

    // --------
    // Wishbone slave
    // --------
    wire req = WB_CYC_I & WB_STB_I;
    wire hit_cmd = (WB_ADR_I == `CCRB_WB_CMD);
    wire hit_stat = (WB_ADR_I == `CCRB_WB_STAT);
    wire busy = (state != H_IDLE);
    wire start_cmd = req & WB_ACK_O & WB_WE_I & hit_cmd & (&WB_SEL_I[2:0]) & ~busy;
    wire [31:0] stat_word = {14'h0000, init_done, busy, rdata};
    wire [31:0] rd_mux = hit_cmd ? {11'h000, cmd} : (hit_stat ? stat_word : 32'h00000000);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'h0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= req & ~WB_ACK_O;
            if (req && !WB_ACK_O) begin
                WB_DAT_O <= rd_mux;
            end
        end
    end

    // --------
    // Frame build
    // --------
    // Config word fixed up so reserved bits stay clear and mode pairs match
    function automatic ccrb_word_t fix_word(input ccrb_addr_t a, input ccrb_word_t d);
        ccrb_word_t v;
        v = d;
        if (a == `CCRB_A_MAIN) begin
            v = d & `CCRB_MAIN_WMASK;
            if (d[`CCRB_B_DES]) begin
                v = v | `CCRB_M_DUAL_EDGE_Q_INPUT_SELECT;
            end
            if (LOW_RATE_CLOCK) begin
                v = v | `CCRB_M_LFS;
            end
        end
        return v;
    endfunction

    wire cmd_is_rd = WB_DAT_I[`CCRB_F_RD];
    wire [3:0] cmd_addr = WB_DAT_I[`CCRB_F_ADDR];
    wire [23:0] user_frame = {cmd_is_rd, `CCRB_RSV_CODE, cmd_addr, 1'h0,
                              fix_word(cmd_addr, WB_DAT_I[`CCRB_F_DATA])};
    wire [23:0] init_frame = {1'h0, `CCRB_RSV_CODE, init_addr, 1'h0,
                              fix_word(init_addr, ccrb_default(init_addr))};
    localparam logic [15:0] IMPL = `CCRB_IMPL_MASK;
    wire half_tick = (tick_cnt == `CCRB_HALF_LAST);
    wire sample_now = (bits_left <= `CCRB_DATA_BITS);

    // --------
    // Returned data synchroniser
    // --------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sdo_sync <= 3'h0;
            sdo_f <= 1'h0;
        end else begin
            sdo_sync <= {sdo_sync[1:0], LINK.sdo_line};
            if (sdo_sync[1] == sdo_sync[2]) begin
                sdo_f <= sdo_sync[2];
            end
        end
    end

    // --------
    // Link sequencer
    // --------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= H_INIT;
            cmd <= 21'h000000;
            rdata <= `CCRB_ZERO;
            init_done <= 1'h0;
            init_addr <= 4'h0;
            tick_cnt <= 4'h0;
            bits_left <= 5'h00;
            frame <= 24'h000000;
            LINK.scs_n <= 1'h1;
            LINK.sclk <= 1'h0;
            LINK.sdi <= 1'h0;
        end else begin
            tick_cnt <= (half_tick || state == H_IDLE) ? 4'h0 : tick_cnt + 4'h1;
            unique case (state)
                // Device NRST also loads defaults; host still writes every default first
                H_INIT: begin
                    if (!IMPL[init_addr]) begin
                        init_addr <= init_addr + 4'h1;
                    end else begin
                        frame <= {init_frame[22:0], 1'h0};
                        LINK.sdi <= init_frame[23];
                        LINK.scs_n <= 1'h0;
                        bits_left <= `CCRB_FRAME_BITS;
                        tick_cnt <= 4'h0;
                        state <= H_LOW;
                    end
                end
                H_IDLE: begin
                    if (start_cmd) begin
                        cmd <= WB_DAT_I[20:0];
                        frame <= {user_frame[22:0], 1'h0};
                        LINK.sdi <= user_frame[23];
                        LINK.scs_n <= 1'h0;
                        bits_left <= `CCRB_FRAME_BITS;
                        state <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_tick) begin
                        LINK.sclk <= 1'h1;
                        if (sample_now) begin
                            rdata <= {rdata[14:0], sdo_f};
                        end
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_tick) begin
                        LINK.sclk <= 1'h0;
                        if (bits_left == 5'h01) begin
                            LINK.scs_n <= 1'h1;
                            state <= H_GAP;
                        end else begin
                            LINK.sdi <= frame[23];
                            frame <= {frame[22:0], 1'h0};
                            bits_left <= bits_left - 5'h01;
                            state <= H_LOW;
                        end
                    end
                end
                H_GAP: begin
                    if (half_tick) begin
                        if (init_done) begin
                            state <= H_IDLE;
                        end else if (init_addr == `CCRB_A_SYNC) begin
                            init_done <= 1'h1;
                            state <= H_IDLE;
                        end else begin
                            init_addr <= init_addr + 4'h1;
                            state <= H_INIT;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// *** bench/ccrb_monitor.sv ***
`timescale 1ns/1ps
module ccrb_monitor (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic scs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    // --------
    // Frame tracking
    // --------
    logic [4:0] rises;
    logic rd_flag;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rises <= 5'h00;
            rd_flag <= 1'b0;
        end else if (scs_n) begin
            rises <= 5'h00;
        end else if ($rose(sclk)) begin
            rises <= rises + 5'h01;
            if (rises == 5'h00) begin
                rd_flag <= sdi;
            end
        end
    end

    // --------
    // Link checks
    // --------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    clk_idle_a: assert property (scs_n |-> !sclk) else $error("sclk in gap");
    frame_gap_a: assert property ($rose(scs_n) |-> scs_n [*8]) else $error("short gap");
    high_time_a: assert property ($rose(sclk) |-> ##12 $fell(sclk)) else $error("bad high time");
    low_time_a: assert property ($fell(sclk) && !scs_n |-> ##12 $rose(sclk)) else $error("bad low time");
    sdi_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdi)) else $error("sdi moved");
    sdo_hold_a: assert property (sdo_oe && sclk && $past(sclk) |-> $stable(sdo_line))
        else $error("sdo moved");
    frame_len_a: assert property ($rose(scs_n) |-> rises == 5'h18) else $error("bad length");
    rsv_code_a: assert property ($rose(sclk) && rises inside {5'h01, 5'h02} |-> sdi == (rises == 5'h01))
        else $error("bad 10b field");
    oe_start_a: assert property ($rose(sdo_oe) |-> !scs_n && rises == 5'h08)
        else $error("early sdo");
    oe_write_a: assert property (sdo_oe |-> rd_flag) else $error("sdo in write");
    oe_release_a: assert property ($rose(scs_n) |-> ##[1:10] !sdo_oe) else $error("sdo held");
endmodule

// *** bench/converter_control_register_bank_tb.sv ***
`timescale 1ns/1ps
`define TB_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module converter_control_register_bank_tb;
    import ccrb_pkg::*;
    // --------
    // Stimulus and wiring
    // --------
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h00000000;
    logic [31:0] wb_dout;
    logic [31:0] wb_q;
    logic wb_ack;
    logic ext_pin = 1'b0;
    logic cal_pin = 1'b0;
    logic pdi_pin = 1'b0;
    logic pdq_pin = 1'b0;
    logic low_rate = 1'b0;
    logic extended_ctrl_mode, cal_start, ddr, swing, pattern_output_select, chan_i_powerdown, chan_q_powerdown, lfs, des, dual_edge_q_input_select, twos;
    ccrb_word_t cmt, iofs, ifsr, qofs, qfsr, dlyc, dlyf, sync;
    logic [8:0] outs;
    logic [7:0] cal_cnt = 8'h00;
    int err_total = 0;
    int num_checks = 0;

    assign outs = {ddr, swing, pattern_output_select, chan_i_powerdown, chan_q_powerdown, lfs, des, dual_edge_q_input_select, twos};
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        if (cal_start === 1'b1) begin
            cal_cnt <= cal_cnt + 8'h01;
        end
    end

    ccrb_link_if ccrb_link_if_inst ();
    ccrb_device ccrb_device_inst (.CLOCK(clock), .NRST(nrst), .LINK(ccrb_link_if_inst.device),
        .EXT_CONTROL_SELECT_PIN(ext_pin), .CAL_PIN(cal_pin), .CHAN_I_POWERDOWN_PIN(pdi_pin),
        .CHAN_Q_POWERDOWN_PIN(pdq_pin), .EXTENDED_CTRL_MODE(extended_ctrl_mode), .CAL_START(cal_start), .DDR_PHASE_SELECT(ddr),
        .OUTPUT_SWING_HIGH(swing), .PATTERN_OUTPUT_SELECT(pattern_output_select), .CHAN_I_POWERDOWN(chan_i_powerdown), .CHAN_Q_POWERDOWN(chan_q_powerdown),
        .SLOW_CLOCK_SELECT(lfs), .DUAL_EDGE_MODE(des), .DUAL_EDGE_Q_INPUT_SELECT(dual_edge_q_input_select), .TWOS_COMP_FORMAT(twos),
        .COMMON_MODE_TRIM(cmt), .I_OFFSET_TRIM(iofs), .I_FULL_SCALE_TRIM(ifsr), .Q_OFFSET_TRIM(qofs),
        .Q_FULL_SCALE_TRIM(qfsr), .DELAY_COARSE(dlyc), .DELAY_FINE_FILTER(dlyf), .SYNC_CTRL(sync));
    ccrb_host ccrb_host_inst (.CLOCK(clock), .NRST(nrst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
        .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_dout), .WB_ACK_O(wb_ack),
        .LOW_RATE_CLOCK(low_rate), .LINK(ccrb_link_if_inst.host));
    ccrb_monitor ccrb_monitor_inst (.CLOCK(clock), .NRST(nrst), .scs_n(ccrb_link_if_inst.scs_n),
        .sclk(ccrb_link_if_inst.sclk), .sdi(ccrb_link_if_inst.sdi), .sdo(ccrb_link_if_inst.sdo),
        .sdo_oe(ccrb_link_if_inst.sdo_oe), .sdo_line(ccrb_link_if_inst.sdo_line));

    // --------
    // Helpers
    // --------
    function automatic ccrb_word_t pat(input ccrb_addr_t a);
        return {a, 4'h6, ~a, 4'h3};
    endfunction

    function automatic logic [8:0] fld(input ccrb_word_t v);
        return {v[14], v[13], v[12], v[11], v[10], v[8], v[7], v[6], v[4]};
    endfunction

    function automatic ccrb_word_t trim(input ccrb_addr_t a);
        case (a)
            4'h1: return cmt;
            4'h2: return iofs;
            4'h3: return ifsr;
            4'ha: return qofs;
            4'hb: return qfsr;
            4'hc: return dlyc;
            4'hd: return dlyf;
            4'he: return sync;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        wb_q = wb_dout;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, 4'h4, 32'h00000000);
            n++;
        end while (!(wb_q[17] === 1'b1 && wb_q[16] === 1'b0) && n < 4000);
        if (n >= 4000) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic xfer(input logic rd, input ccrb_addr_t a, input ccrb_word_t d);
        wb(1'b1, 4'h0, {11'h000, rd, a, d});
        wait_idle();
    endtask

    task automatic pins_settle();
        repeat (10) @(posedge clock);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_defaults();
        `TB_CHK(extended_ctrl_mode, 1'b1)
        `TB_CHK(outs, fld(16'h2000))
        `TB_CHK(ifsr, 16'h4000)
        xfer(1'b1, 4'h0, 16'h0000);
        `TB_CHK(wb_q[15:0], 16'h2000)
        wb(1'b0, 4'h8, 32'h00000000);
        `TB_CHK(wb_q, 32'h00000000)
        wb(1'b0, 4'h0, 32'h00000000);
        `TB_CHK(wb_q, 32'h00100000)
        $display("defaults test done");
    endtask

    task automatic t_map();
        ccrb_word_t e;
        for (int a = 1; a < 16; a++) begin
            xfer(1'b0, a[3:0], pat(a[3:0]));
        end
        for (int a = 1; a < 16; a++) begin
            e = (a inside {1, 2, 3, 10, 11, 12, 13, 14}) ? pat(a[3:0]) : 16'h0000;
            xfer(1'b1, a[3:0], 16'h0000);
            `TB_CHK(wb_q[15:0], e)
            `TB_CHK(trim(a[3:0]), e)
        end
        $display("address map test done");
    endtask

    task automatic t_main();
        ccrb_word_t v[10];
        ccrb_word_t e;
        v = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0100, 16'h0080, 16'h0010, 16'h7fff, 16'h0000};
        foreach (v[i]) begin
            e = v[i] & 16'hfdd0;
            e[6] = e[6] | v[i][7];
            xfer(1'b0, 4'h0, v[i]);
            xfer(1'b1, 4'h0, 16'h0000);
            `TB_CHK(wb_q[15:0], e)
            `TB_CHK(outs, fld(e))
        end
        @(posedge clock);
        low_rate <= 1'b1;
        xfer(1'b0, 4'h0, 16'h0000);
        xfer(1'b1, 4'h0, 16'h0000);
        `TB_CHK(wb_q[15:0], 16'h0100)
        low_rate <= 1'b0;
        xfer(1'b0, 4'h0, 16'h0000);
        $display("main config test done");
    endtask

    task automatic cal_step(input logic pin, input ccrb_word_t v, input logic [7:0] inc);
        logic [7:0] c0;
        c0 = cal_cnt;
        if (pin) begin
            @(posedge clock);
            cal_pin <= v[0];
        end else begin
            xfer(1'b0, 4'h0, v);
        end
        pins_settle();
        `TB_CHK(cal_cnt, c0 + inc)
    endtask

    task automatic t_cal();
        cal_step(1'b0, 16'h8000, 8'h01);
        cal_step(1'b0, 16'h8000, 8'h00);
        cal_step(1'b0, 16'h0000, 8'h00);
        cal_step(1'b0, 16'h8000, 8'h01);
        cal_step(1'b1, 16'h0001, 8'h00);
        cal_step(1'b0, 16'h0000, 8'h00);
        cal_step(1'b1, 16'h0000, 8'h00);
        cal_step(1'b1, 16'h0001, 8'h01);
        cal_step(1'b1, 16'h0000, 8'h00);
        $display("calibration test done");
    endtask

    task automatic t_pins();
        @(posedge clock);
        pdi_pin <= 1'b1;
        pins_settle();
        `TB_CHK({chan_i_powerdown, chan_q_powerdown}, 2'b10)
        pdi_pin <= 1'b0;
        pdq_pin <= 1'b1;
        pins_settle();
        `TB_CHK({chan_i_powerdown, chan_q_powerdown}, 2'b01)
        pdq_pin <= 1'b0;
        xfer(1'b0, 4'h0, 16'h5c00);
        `TB_CHK({chan_i_powerdown, chan_q_powerdown, iofs}, {2'b11, pat(4'h2)})
        @(posedge clock);
        ext_pin <= 1'b1;
        pins_settle();
        `TB_CHK({extended_ctrl_mode, outs}, {1'b0, fld(16'h2000)})
        `TB_CHK(cmt, 16'h2a00)
        xfer(1'b0, 4'h1, 16'h1111);
        @(posedge clock);
        ext_pin <= 1'b0;
        pins_settle();
        `TB_CHK(extended_ctrl_mode, 1'b1)
        xfer(1'b1, 4'h1, 16'h0000);
        `TB_CHK(wb_q[15:0], 16'h2a00)
        xfer(1'b1, 4'h0, 16'h0000);
        `TB_CHK(wb_q[15:0], 16'h2000)
        $display("pin control test done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        wait_idle();
        t_defaults();
        t_map();
        t_main();
        t_cal();
        t_pins();
        summarize();
    end
endmodule
